// file: shared/accel_fifo_map.vh
`ifndef ACCEL_FIFO_MAP_VH
`define ACCEL_FIFO_MAP_VH

// Register offsets.
`define REG_FIFO_STATUS 8'h00
`define REG_OUT_X_HI 8'h01
`define REG_OUT_X_LO 8'h02
`define REG_OUT_Y_HI 8'h03
`define REG_OUT_Y_LO 8'h04
`define REG_OUT_Z_HI 8'h05
`define REG_OUT_Z_LO 8'h06
`define REG_BUF_SETUP 8'h09
`define REG_POST_TRIG 8'h0A
`define REG_TRIG_STATUS 8'h0B
`define REG_RANGE_CFG 8'h0E
`define REG_PRIMARY_CTRL 8'h2A
`define REG_USER_OFF_BASE 8'h2F
`define USER_OFF_REGS 8'h06

// In fast read mode the three high bytes sit at 0x01..0x03.
`define REG_FAST_Z_HI 8'h03

// Field positions.
`define SETUP_MODE_MSB 7
`define SETUP_MODE_LSB 6
`define SETUP_WM_MSB 5
`define SETUP_WM_LSB 0
`define CTRL_ACTIVE_BIT 0
`define CTRL_FAST_BIT 1

// Buffer modes.
`define MODE_DISABLED 2'h0
`define MODE_CIRCULAR 2'h1
`define MODE_FILL 2'h2
`define MODE_TRIGGER 2'h3

// Full-scale range codes.
`define RANGE_2G 2'h0
`define RANGE_4G 2'h1
`define RANGE_8G 2'h2

// Reset values.
`define SETUP_RESET 8'h00
`define CTRL_RESET 8'h00
`define RANGE_RESET 2'h0
`define POST_TRIG_RESET 6'h00
`define USER_OFF_RESET 8'h00

// Output code limits of a 14-bit two's complement sample.
`define CODE_MAX 19'sh0_1fff
`define CODE_MIN 19'sh7_e000
`define CODE_POS_SAT 14'h1fff
`define CODE_NEG_SAT 14'h2000

// Trim words read at start-up and the sensitivity trim shift.
`define TRIM_WORDS 3'h6
`define GAIN_SHIFT 9

`endif

// file: design/trim_loader.v
`timescale 1ns/1ps
`include "accel_fifo_map.vh"

module trim_loader #(
    parameter [2:0] WORDS = `TRIM_WORDS
) (
    input wire i_clk, // System clock.
    input wire i_reset, // Synchronous reset, active high.
    output wire o_trim_rd, // Read strobe to trim storage.
    output wire [2:0] o_trim_addr, // Trim word address.
    input wire [7:0] i_trim_data, // Trim word, valid the cycle after the strobe.
    output wire [8*WORDS-1:0] o_trim_values, // All trim words, word 0 lowest.
    output wire o_done // High once every trim word is loaded.
);
    localparam [2:0] ST_ISSUE = 3'b001;
    localparam [2:0] ST_CAPTURE = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;
    localparam [2:0] LAST_IDX = WORDS - 3'h1;

    reg [2:0] state;
    reg [2:0] idx;
    reg [8*WORDS-1:0] values;

    assign o_trim_rd = (state == ST_ISSUE);
    assign o_trim_addr = idx;
    assign o_trim_values = values;
    assign o_done = (state == ST_DONE);

    always @(posedge i_clk) begin
        if (i_reset) begin
            state <= ST_ISSUE;
            idx <= 3'h0;
            values <= {(8*WORDS){1'b0}};
        end else begin
            case (state)
                ST_ISSUE: begin
                    state <= ST_CAPTURE;
                end
                ST_CAPTURE: begin
                    values[{idx, 3'b000} +: 8] <= i_trim_data;
                    if (idx == LAST_IDX) begin
                        state <= ST_DONE;
                    end else begin
                        idx <= idx + 3'h1;
                        state <= ST_ISSUE;
                    end
                end
                ST_DONE: begin
                    state <= ST_DONE;
                end
                default: begin
                    state <= ST_ISSUE;
                end
            endcase
        end
    end
endmodule

// file: design/accel_sample_fifo.v
`timescale 1ns/1ps
`include "accel_fifo_map.vh"
// How it works
// - Each axis is a 14-bit two's complement code over a high and low byte.
// - High byte holds the top eight bits, low byte the remaining six.
// - Fast read set: only the three high bytes are offered, contiguously.
// - Fast read clear: full data, low bytes included, is returned.
// - 2g range spans -8192..8191 counts, 4096 counts per g.
// - 8g range spans -8192..8191 counts, 1024 counts per g.
// - The 8-bit result is the 14-bit code without its six lowest bits.
// - Buffer, trims and formatting work alike in 2g, 4g and 8g.
// - Buffer holds up to 32 three-axis samples without host activity.
// - Any sample strobe while active and after trim load is accepted, with no rate-dependent limit.
// - Buffered samples read out at 14-bit width or as high bytes only.
// - Setup register at 0x09 picks fill, circular, trigger or disabled.
// - Fill mode stores 32 samples, flags overflow on one more.
// - Full fill buffer drops samples until the host reads some out.
// - Circular mode overwrites the oldest sample, keeping the newest 32.
// - Trigger mode keeps pre-trigger data, then captures N more, then holds.
// - Watermark flag rises when fill level reaches the 1..32 setting.
// - Sensitivity and offset trims load from trim storage after reset.
// - Six volatile user offset registers shift each axis zero-g offset.
// - 4g range gives 2048 counts per g.
// - Leaving active mode keeps every register and the buffer intact.

module accel_sample_fifo #(
    parameter AW = 5 // Pointer width; the buffer holds two to this power samples.
) (
    input wire i_clk, // System clock, 125 MHz.
    input wire i_reset, // Synchronous reset, active high.
    input wire i_sample_valid, // One-cycle strobe: new acceleration sample.
    input wire [15:0] i_accel_x, // X acceleration, signed, 1/4096 g units.
    input wire [15:0] i_accel_y, // Y acceleration, signed, 1/4096 g units.
    input wire [15:0] i_accel_z, // Z acceleration, signed, 1/4096 g units.
    input wire i_trigger, // One-cycle trigger event for trigger mode.
    input wire [7:0] i_reg_addr, // Register offset.
    input wire i_reg_wr, // Register write strobe.
    input wire i_reg_rd, // Register read strobe.
    input wire [7:0] i_reg_wdata, // Register write data.
    output wire [7:0] o_reg_rdata, // Read data, valid with o_reg_rvalid.
    output wire o_reg_rvalid, // One-cycle pulse after a read strobe.
    output wire o_trim_rd, // Trim storage read strobe.
    output wire [2:0] o_trim_addr, // Trim storage word address.
    input wire [7:0] i_trim_data, // Trim storage data, one cycle after strobe.
    output wire o_trim_done, // Trims loaded; samples accepted from now on.
    output wire o_watermark, // Fill level at or above the watermark.
    output wire o_overflow // Sticky overflow flag.
);
    reg [7:0] setup;
    reg [7:0] ctrl;
    reg [1:0] range;
    reg [5:0] post_count;
    reg [7:0] user_off [0:5];
    reg [13:0] last_x;
    reg [13:0] last_y;
    reg [13:0] last_z;
    reg [41:0] mem [0:(1<<AW)-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    reg [AW:0] next_count;
    reg overflow;
    reg wm_flag;
    reg triggered;
    reg [5:0] post_left;
    reg [7:0] rdata;
    reg rvalid;
    reg [7:0] read_mux;
    wire [47:0] trim;
    wire trim_done;
    integer i;

    // Gain trim is a signed fraction of 1/512; the user offset is in 2g counts so it
    // scales with the range like the signal itself.
    function [13:0] axis_conv;
        input [15:0] accel;
        input [7:0] gain;
        input [7:0] trim_off;
        input [15:0] uoff;
        input [1:0] rsel;
        reg signed [23:0] prod;
        reg signed [18:0] sum;
        reg signed [18:0] scaled;
        begin
            prod = $signed(accel) * $signed(gain);
            sum = {{3{accel[15]}}, accel} + {{4{prod[23]}}, prod[23:`GAIN_SHIFT]}
                + {{11{trim_off[7]}}, trim_off} + {{3{uoff[15]}}, uoff};
            case (rsel)
                `RANGE_4G: scaled = sum >>> 1;
                `RANGE_8G: scaled = sum >>> 2;
                default: scaled = sum;
            endcase
            if (scaled > `CODE_MAX) begin
                axis_conv = `CODE_POS_SAT;
            end else if (scaled < `CODE_MIN) begin
                axis_conv = `CODE_NEG_SAT;
            end else begin
                axis_conv = scaled[13:0];
            end
        end
    endfunction

    trim_loader #(
        .WORDS(`TRIM_WORDS)
    ) u_trim (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .o_trim_rd(o_trim_rd),
        .o_trim_addr(o_trim_addr),
        .i_trim_data(i_trim_data),
        .o_trim_values(trim),
        .o_done(trim_done)
    );

    wire [1:0] mode = setup[`SETUP_MODE_MSB:`SETUP_MODE_LSB];
    wire [5:0] wm = setup[`SETUP_WM_MSB:`SETUP_WM_LSB];
    wire fast = ctrl[`CTRL_FAST_BIT];
    wire active = ctrl[`CTRL_ACTIVE_BIT];
    wire buf_on = (mode != `MODE_DISABLED);
    wire sample_in = i_sample_valid & active & trim_done;
    wire full = count[AW];
    wire empty = (count == {(AW+1){1'b0}});
    wire hold = triggered & (post_left == 6'h00);
    wire [7:0] last_addr = fast ? `REG_FAST_Z_HI : `REG_OUT_Z_LO;
    wire pop = i_reg_rd & (i_reg_addr == last_addr) & buf_on & ~empty;
    // Fill mode refuses when full unless a read frees a slot in the same cycle.
    wire take = sample_in & buf_on & ~hold & (~full | pop | (mode != `MODE_FILL));
    wire overwrite = take & full & ~pop;
    wire ovf_set = sample_in & buf_on & full & ~pop;
    wire trig_fire = i_trigger & (mode == `MODE_TRIGGER) & ~triggered;
    wire setup_wr = i_reg_wr & (i_reg_addr == `REG_BUF_SETUP);
    wire status_rd = i_reg_rd & (i_reg_addr == `REG_FIFO_STATUS);
    wire [7:0] uoff_rel = i_reg_addr - `REG_USER_OFF_BASE;
    wire in_user = (uoff_rel < `USER_OFF_REGS);

    wire [13:0] conv_x = axis_conv(i_accel_x, trim[7:0], trim[31:24],
                                   {user_off[0], user_off[1]}, range);
    wire [13:0] conv_y = axis_conv(i_accel_y, trim[15:8], trim[39:32],
                                   {user_off[2], user_off[3]}, range);
    wire [13:0] conv_z = axis_conv(i_accel_z, trim[23:16], trim[47:40],
                                   {user_off[4], user_off[5]}, range);

    // With the buffer on and holding data, the output bytes show its oldest sample.
    wire [41:0] head = mem[rd_ptr];
    wire [41:0] shown = (buf_on & ~empty) ? head : {last_x, last_y, last_z};

    always @* begin
        next_count = count;
        case ({take & ~overwrite, pop})
            2'b10: next_count = count + {{AW{1'b0}}, 1'b1};
            2'b01: next_count = count - {{AW{1'b0}}, 1'b1};
            default: next_count = count;
        endcase
    end

    always @* begin
        read_mux = 8'h00;
        case (i_reg_addr)
            `REG_FIFO_STATUS: read_mux = {overflow, wm_flag, count[5:0]};
            `REG_OUT_X_HI: read_mux = shown[41:34];
            `REG_OUT_X_LO: read_mux = fast ? shown[27:20] : {shown[33:28], 2'b00};
            `REG_OUT_Y_HI: read_mux = fast ? shown[13:6] : shown[27:20];
            `REG_OUT_Y_LO: read_mux = fast ? 8'h00 : {shown[19:14], 2'b00};
            `REG_OUT_Z_HI: read_mux = fast ? 8'h00 : shown[13:6];
            `REG_OUT_Z_LO: read_mux = fast ? 8'h00 : {shown[5:0], 2'b00};
            `REG_BUF_SETUP: read_mux = setup;
            `REG_POST_TRIG: read_mux = {2'b00, post_count};
            `REG_TRIG_STATUS: read_mux = {6'h00, hold, triggered};
            `REG_RANGE_CFG: read_mux = {6'h00, range};
            `REG_PRIMARY_CTRL: read_mux = ctrl;
            default: begin
                if (in_user) begin
                    read_mux = user_off[uoff_rel[2:0]];
                end
            end
        endcase
    end

    // Registers and buffer contents carry no dependence on the active bit, so going
    // to standby keeps them; the active bit only gates new samples.
    always @(posedge i_clk) begin
        if (i_reset) begin
            setup <= `SETUP_RESET;
            ctrl <= `CTRL_RESET;
            range <= `RANGE_RESET;
            post_count <= `POST_TRIG_RESET;
            for (i = 0; i < 6; i = i + 1) begin
                user_off[i] <= `USER_OFF_RESET;
            end
            last_x <= 14'h0000;
            last_y <= 14'h0000;
            last_z <= 14'h0000;
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            overflow <= 1'b0;
            wm_flag <= 1'b0;
            triggered <= 1'b0;
            post_left <= 6'h00;
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            if (i_reg_wr) begin
                case (i_reg_addr)
                    `REG_BUF_SETUP: setup <= i_reg_wdata;
                    `REG_POST_TRIG: post_count <= i_reg_wdata[5:0];
                    `REG_RANGE_CFG: range <= i_reg_wdata[1:0];
                    `REG_PRIMARY_CTRL: ctrl <= i_reg_wdata;
                    default: begin
                        if (in_user) begin
                            user_off[uoff_rel[2:0]] <= i_reg_wdata;
                        end
                    end
                endcase
            end
            if (sample_in) begin
                last_x <= conv_x;
                last_y <= conv_y;
                last_z <= conv_z;
            end
            if (take) begin
                mem[wr_ptr] <= {conv_x, conv_y, conv_z};
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop | overwrite) begin
                rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            count <= next_count;
            // A new overflow in the cycle of the status read survives the clear.
            overflow <= ovf_set | (overflow & ~status_rd);
            wm_flag <= buf_on & (wm != 6'h00) & (count >= wm);
            if (trig_fire) begin
                triggered <= 1'b1;
                post_left <= post_count;
            end else if (setup_wr) begin
                triggered <= 1'b0;
            end else if (take & triggered & (post_left != 6'h00)) begin
                post_left <= post_left - 6'h01;
            end
            rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                rdata <= read_mux;
            end
            if (~buf_on) begin
                wr_ptr <= {AW{1'b0}};
                rd_ptr <= {AW{1'b0}};
                count <= {(AW+1){1'b0}};
                overflow <= 1'b0;
                triggered <= 1'b0;
                post_left <= 6'h00;
            end
        end
    end

    assign o_reg_rdata = rdata;
    assign o_reg_rvalid = rvalid;
    assign o_trim_done = trim_done;
    assign o_watermark = wm_flag;
    assign o_overflow = overflow;
endmodule

// file: verif/trim_store_model.sv
`timescale 1ns/1ps

module trim_store_model (
    input logic i_clk, // Clock.
    input logic i_trim_rd, // Trim read strobe.
    output logic [7:0] o_data // Trim word.
);
    // Zero trims keep expected codes exact; between reads the lines toggle so
    // a late capture shows up as a wrong code.
    initial o_data = 8'h5A;
    always @(posedge i_clk) o_data <= i_trim_rd ? 8'h00 : ~o_data;
endmodule

// file: verif/accel_sample_fifo_chk.sv
`timescale 1ns/1ps
`include "accel_fifo_map.vh"

module accel_sample_fifo_chk (
    input logic i_clk, // Clock.
    input logic i_reset, // Reset.
    input logic i_reg_rd, // Read strobe.
    input logic i_reg_wr, // Write strobe.
    input logic [7:0] i_reg_addr, // Offset.
    input logic [7:0] i_reg_wdata, // Write data.
    input logic [7:0] o_reg_rdata, // Read data.
    input logic o_reg_rvalid, // Read valid.
    input logic o_trim_rd, // Trim strobe.
    input logic [2:0] o_trim_addr, // Trim address.
    input logic o_trim_done, // Trims loaded.
    input logic o_watermark, // Watermark flag.
    input logic o_overflow // Overflow flag.
);
    logic [7:0] setup;
    logic fast;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            setup <= `SETUP_RESET;
            fast <= 1'b0;
        end else if (i_reg_wr && i_reg_addr == `REG_BUF_SETUP) begin
            setup <= i_reg_wdata;
        end else if (i_reg_wr && i_reg_addr == `REG_PRIMARY_CTRL) begin
            fast <= i_reg_wdata[`CTRL_FAST_BIT];
        end
    end
    sequence load_seq;
        !o_trim_done [*8] ##[1:10] o_trim_done;
    endsequence
    sequence two_rd;
        o_trim_rd ##2 o_trim_rd;
    endsequence
    rd_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read got no answer");
    rd_only_a: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("answer without read");
    fast_hole_a: assert property (fast && i_reg_rd && i_reg_addr > 8'h03 &&
        i_reg_addr < 8'h07 |=> o_reg_rdata == 8'h00) else $error("low byte in fast read");
    ov_hold_a: assert property (o_overflow && setup[7:6] != `MODE_DISABLED &&
        !(i_reg_rd && i_reg_addr == 8'h00) |=> o_overflow) else $error("overflow lost");
    ov_clear_a: assert property (setup[7:6] == `MODE_DISABLED |=> !o_overflow)
        else $error("overflow while disabled");
    wm_off_a: assert property (setup[7:6] == `MODE_DISABLED || setup[5:0] == 6'h00
        |-> ##2 !o_watermark) else $error("watermark without setting");
    trim_pulse_a: assert property (o_trim_rd |=> !o_trim_rd)
        else $error("trim strobe too long");
    trim_step_a: assert property (two_rd |-> o_trim_addr == $past(o_trim_addr, 2) + 3'h1)
        else $error("trim address skipped");
    load_done_a: assert property ($fell(i_reset) |-> load_seq)
        else $error("trim load time wrong");
    done_stays_a: assert property (o_trim_done |=> o_trim_done && !o_trim_rd)
        else $error("trim done dropped");
endmodule

bind accel_sample_fifo accel_sample_fifo_chk i_accel_sample_fifo_chk (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_reg_rd(i_reg_rd),
    .i_reg_wr(i_reg_wr),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid),
    .o_trim_rd(o_trim_rd),
    .o_trim_addr(o_trim_addr),
    .o_trim_done(o_trim_done),
    .o_watermark(o_watermark),
    .o_overflow(o_overflow)
);

// file: verif/accel_sample_fifo_test.sv
`timescale 1ns/1ps

module accel_sample_fifo_test;
    logic i_clk = 0, i_reset = 1, i_sample_valid = 0, i_trigger = 0;
    logic i_reg_wr = 0, i_reg_rd = 0;
    logic [15:0] i_accel_x = 0, i_accel_y = 0, i_accel_z = 0;
    logic [7:0] i_reg_addr = 0, i_reg_wdata = 0, o_reg_rdata, i_trim_data;
    logic o_reg_rvalid, o_trim_rd, o_trim_done, o_watermark, o_overflow;
    logic [2:0] o_trim_addr;
    int fail_count = 0, compares = 0;
    accel_sample_fifo #(.AW(5)) i_accel_sample_fifo (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_sample_valid(i_sample_valid),
        .i_accel_x(i_accel_x),
        .i_accel_y(i_accel_y),
        .i_accel_z(i_accel_z),
        .i_trigger(i_trigger),
        .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd),
        .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata),
        .o_reg_rvalid(o_reg_rvalid),
        .o_trim_rd(o_trim_rd),
        .o_trim_addr(o_trim_addr),
        .i_trim_data(i_trim_data),
        .o_trim_done(o_trim_done),
        .o_watermark(o_watermark),
        .o_overflow(o_overflow)
    );
    trim_store_model i_trim_store_model (.i_clk(i_clk), .i_trim_rd(o_trim_rd),
        .o_data(i_trim_data));
    initial forever #4 i_clk = ~i_clk;
    function logic [13:0] conv(input logic signed [15:0] a, input int r);
        logic signed [15:0] s;
        s = a >>> r;
        if (s > 16'sh1FFF) return 14'h1FFF;
        if (s < -16'sh2000) return 14'h2000;
        return s[13:0];
    endfunction
    task stop_test;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cmp(input logic [7:0] got, exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One access costs two cycles so no strobe is lowered and raised at once.
    task acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = w;
        i_reg_rd = !w;
        @(posedge i_clk);
        #1;
        q = o_reg_rdata;
        if (!w) cmp({7'h00, o_reg_rvalid}, 8'h01, "rvalid");
        i_reg_wr = 0;
        i_reg_rd = 0;
        @(posedge i_clk);
        #1;
    endtask
    task wr(input logic [7:0] a, d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask
    task chk(input logic [7:0] a, e);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        cmp(q, e, "read");
    endtask
    task pushn(input int k0, n);
        for (int i = 0; i < n; i++) begin
            i_accel_x = 16'((k0 + i) * 16'h0064);
            i_accel_y = -i_accel_x;
            i_accel_z = 16'(16'h1388 + k0 + i);
            i_sample_valid = 1;
            @(posedge i_clk);
            #1;
        end
        i_sample_valid = 0;
    endtask
    task rds(input int k, r, fast);
        logic [13:0] c[3];
        c[0] = conv(16'(k * 16'h0064), r);
        c[1] = conv(-16'(k * 16'h0064), r);
        c[2] = conv(16'(16'h1388 + k), r);
        for (int j = 0; j < 3; j++) begin
            if (fast) begin
                chk(8'(1 + j), c[j][13:6]);
            end else begin
                chk(8'(1 + 2 * j), c[j][13:6]);
                chk(8'(2 + 2 * j), {c[j][5:0], 2'b00});
            end
        end
    endtask
    task t_fill;
        wr(8'h2A, 8'h01);
        wr(8'h09, 8'hA0);
        pushn(0, 33);
        cmp({6'h00, o_overflow, o_watermark}, 8'h03, "flags");
        chk(8'h00, 8'hE0);
        rds(0, 0, 0);
        rds(1, 0, 0);
        pushn(40, 1);
        chk(8'h00, 8'h1F);
        cmp({6'h00, o_overflow, o_watermark}, 8'h00, "flags");
        $display("fill test done");
    endtask
    task t_circ;
        wr(8'h09, 8'h00);
        chk(8'h00, 8'h00);
        wr(8'h09, 8'h41);
        pushn(0, 34);
        chk(8'h00, 8'hE0);
        rds(2, 0, 0);
        $display("circular test done");
    endtask
    task t_fast;
        wr(8'h2A, 8'h03);
        rds(3, 0, 1);
        chk(8'h04, 8'h00);
        wr(8'h2A, 8'h01);
        rds(4, 0, 0);
        $display("fast read test done");
    endtask
    task t_trig;
        wr(8'h09, 8'h00);
        wr(8'h0A, 8'h02);
        wr(8'h09, 8'hC0);
        pushn(0, 3);
        i_trigger = 1;
        @(posedge i_clk);
        #1;
        i_trigger = 0;
        pushn(3, 5);
        chk(8'h00, 8'h05);
        chk(8'h0B, 8'h03);
        wr(8'h2A, 8'h00);
        chk(8'h09, 8'hC0);
        chk(8'h0A, 8'h02);
        chk(8'h00, 8'h05);
        wr(8'h2A, 8'h01);
        rds(0, 0, 0);
        $display("trigger test done");
    endtask
    task t_range;
        wr(8'h09, 8'h00);
        for (int r = 0; r < 3; r++) begin
            wr(8'h0E, 8'(r));
            pushn(120, 1);
            rds(120, r, 0);
        end
        $display("range test done");
    endtask
    // Offsets are 16-bit signed per axis in 2g counts: X gets +16, Y gets -16.
    task t_uoff;
        logic [13:0] c;
        chk(8'h2F, 8'h00);
        wr(8'h30, 8'h10);
        wr(8'h31, 8'hFF);
        wr(8'h32, 8'hF0);
        chk(8'h31, 8'hFF);
        for (int r = 0; r < 2; r++) begin
            wr(8'h0E, 8'(r));
            pushn(1, 1);
            c = conv(16'h0074, r);
            chk(8'h01, c[13:6]);
            chk(8'h02, {c[5:0], 2'b00});
            c = conv(16'hFF8C, r);
            chk(8'h03, c[13:6]);
            chk(8'h04, {c[5:0], 2'b00});
        end
        $display("user offset test done");
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        #1;
        i_reset = 0;
        for (int i = 0; i < 40 && o_trim_done !== 1'b1; i++) begin
            @(posedge i_clk);
            #1;
        end
        cmp({7'h00, o_trim_done}, 8'h01, "trim done");
        t_fill();
        t_circ();
        t_fast();
        t_trig();
        t_range();
        t_uoff();
        stop_test();
    end
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end
endmodule
